// >>> src/pm_sci_pkg.sv
package pm_sci_pkg;

  // Count clock and reference clock rates.
  localparam int REF_CLK_HZ   = 14318180;
  localparam int COUNT_CLK_HZ = 3579545;
  localparam int REF_DIV      = REF_CLK_HZ / COUNT_CLK_HZ;

  localparam int COUNT_W      = 24;
  localparam int COUNT_MSB    = 23;

  // Register offsets within each block.
  localparam logic [3:0] OFS_STS_A     = 4'h0;
  localparam logic [3:0] OFS_STS_B     = 4'h1;
  localparam logic [3:0] OFS_EN_A      = 4'h2;
  localparam logic [3:0] OFS_CNT_LOW   = 4'h8;
  localparam logic [3:0] OFS_CNT_MID   = 4'h9;
  localparam logic [3:0] OFS_CNT_HIGH  = 4'ha;
  localparam logic [3:0] OFS_CNT_SPARE = 4'hb;

  // Field positions and reset values.
  localparam int         STS_B_IR_BIT  = 2;
  localparam int         STS_B_BTN_BIT = 3;
  localparam int         EN_B_W        = 6;
  localparam logic [7:0] EN_A_RST      = 8'h00;
  localparam logic [7:0] CNT_SPARE_VAL = 8'h00;
  localparam logic [7:0] RDATA_RST     = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RST = 24'h000000;

  // Pin synchroniser lanes.
  localparam int PIN_BUS_RST = 0;
  localparam int PIN_SB_POR  = 1;
  localparam int PIN_IR_B    = 2;
  localparam int PIN_GENERAL_PIN_TWELVE    = 3;
  localparam int PIN_N       = 4;

  typedef enum logic {
    BLK_PM  = 1'b0,
    BLK_MSC = 1'b1
  } blk_sel_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    blk_sel_t   blk;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic watchdog_irq_status;
    logic group_a_irq_status;
    logic group_b_irq_status;
    logic floppy_irq_status;
    logic serial_a_irq_status;
    logic serial_b_irq_status;
    logic parallel_irq_status;
    logic drive_iface_irq_status;
  } src_status_a_t;

  typedef struct packed {
    logic mgmt_bus_irq_status;
    logic kbc_port_pin_status;
    logic keyboard_irq_status;
    logic mouse_irq_status;
  } src_status_b_t;

endpackage

// >>> src/ref_tick_divider.sv
module ref_tick_divider
  import pm_sci_pkg::*;
#(
  parameter int DIV = REF_DIV
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ref_clk_pin,
  output logic      tick_r
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic          meta_r;
  logic          sync_r;
  logic          prev_r;
  logic [CW-1:0] div_r;
  logic          edge_seen;

  assign edge_seen = sync_r & ~prev_r;

  always_ff @(posedge sys_clk) begin
    meta_r <= ref_clk_pin;
    sync_r <= meta_r;
    prev_r <= sync_r;
  end

  // A stopped reference gives no edges and therefore no ticks.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (edge_seen) begin
        if (div_r == LAST) begin
          div_r  <= '0;
          tick_r <= 1'b1;
        end else begin
          div_r <= div_r + 1'b1;
        end
      end
    end
  end

endmodule

// >>> src/pm_timer_sci_status.sv
// Function
// RL1: 24-bit counter at count rate while working.
// RL2: Bus reset or standby reset zero count.
// RL3: Stopped reference clock holds count value.
// RL4: Any count bit 23 change sets flag; a change from a bus or standby reset clearing the count does not set it.
// RL5: Flag plus event enable raises interrupt.
// RL6: Mid and high count bytes read-only.
// RL7: Spare count byte reads zero.
// RL8: First status register shows eight sources.
// RL9: Second status shows sources; bits 7:6 zero.
// RL10: Selected infrared pin edge sets bit 2.
// RL11: Button delay start sets bit 3.
// RL12: Write one clears bits 2,3; zero ignored.
// RL13: Standby reset clears status bits 2,3.
// RL14: First enable register read/write, resets zero.
// RL15: Enables gate sources onto group and pin.
// RL16: Group is OR of status AND enable.
// RL17: Low byte read latches upper bytes.
// RL18: Master enable gates interrupt output.
// RL19: Run control stops or runs counter.
module pm_timer_sci_status
  import pm_sci_pkg::*;
#(
  parameter int DIV = REF_DIV
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire reg_req_t      reg_req,
  output logic [7:0]         reg_rdata_r,
  input  wire logic          ref_clk_pin,
  input  wire logic          bus_reset_input,
  input  wire logic          standby_power_on_reset,
  input  wire logic          working_state,
  input  wire logic          count_run_control,
  input  wire logic          count_event_enable,
  input  wire logic          sci_master_enable,
  input  wire logic          count_flag_clear,
  input  wire src_status_a_t src_a_in,
  input  wire src_status_b_t src_b_in,
  input  wire logic          infrared_rx_pin_b,
  input  wire logic          general_pin_twelve,
  input  wire logic          ir_pin_select,
  input  wire logic          button_delay_start,
  input  wire logic [EN_B_W-1:0] sci_enable_b,
  output logic               count_msb_toggle_flag_r,
  output logic               group_sci_r,
  output logic               sci_irq_r
);

  logic [PIN_N-1:0]   pin_meta_r;
  logic [PIN_N-1:0]   pin_sync_r;
  logic               count_tick;
  logic               count_clr;
  logic               count_inc;
  logic [COUNT_W-1:0] pm_count_value_r;
  logic [COUNT_W-1:0] pm_count_value_nxt;
  logic [15:0]        count_snap_r;
  logic [7:0]         sci_source_enable_a_r;
  logic               ir_flag_r;
  logic               btn_flag_r;
  logic               ir_level_r;
  logic               ir_mux;
  logic               ir_edge;
  logic               rd_pm;
  logic               rd_msc;
  logic               wr_msc;
  logic [7:0]         sts_a;
  logic [7:0]         sts_b;
  logic [7:0]         rdata_nxt;
  logic               group_nxt;
  logic               msb_flip;

  // Pins outside the clock domain pass two flip-flops first.
  always_ff @(posedge sys_clk) begin
    pin_meta_r <= {general_pin_twelve, infrared_rx_pin_b,
                   standby_power_on_reset, bus_reset_input};
    pin_sync_r <= pin_meta_r;
  end

  ref_tick_divider #(
    .DIV (DIV)
  ) u_tick (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .ref_clk_pin (ref_clk_pin),
    .tick_r      (count_tick)
  );

  assign count_clr = pin_sync_r[PIN_BUS_RST] | pin_sync_r[PIN_SB_POR];
  assign count_inc = count_tick & working_state & count_run_control; // RL1 RL19
  assign pm_count_value_nxt = pm_count_value_r + 1'b1;
  assign msb_flip = pm_count_value_nxt[COUNT_MSB] ^
                    pm_count_value_r[COUNT_MSB];

  // Without ticks the count simply stands, so a restart resumes from it.
  always_ff @(posedge sys_clk) begin
    if (rst || count_clr) begin
      pm_count_value_r <= COUNT_RST; // RL2
    end else if (count_inc) begin
      pm_count_value_r <= pm_count_value_nxt; // RL1 RL3
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst || pin_sync_r[PIN_SB_POR]) begin
      count_msb_toggle_flag_r <= 1'b0;
    end else if (!count_clr && count_inc && msb_flip) begin
      count_msb_toggle_flag_r <= 1'b1; // RL4
    end else if (count_flag_clear) begin
      count_msb_toggle_flag_r <= 1'b0;
    end
  end

  assign rd_pm  = reg_req.rd && (reg_req.blk == BLK_PM);
  assign rd_msc = reg_req.rd && (reg_req.blk == BLK_MSC);
  assign wr_msc = reg_req.wr && (reg_req.blk == BLK_MSC);

  // Reading the low byte freezes the upper two for a coherent value.
  always_ff @(posedge sys_clk) begin
    if (rst || count_clr) begin
      count_snap_r <= 16'h0000;
    end else if (rd_pm && reg_req.addr == OFS_CNT_LOW) begin
      count_snap_r <= pm_count_value_r[23:8]; // RL17
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || pin_sync_r[PIN_SB_POR]) begin
      sci_source_enable_a_r <= EN_A_RST; // RL14
    end else if (wr_msc && reg_req.addr == OFS_EN_A) begin
      sci_source_enable_a_r <= reg_req.wdata; // RL14
    end
  end

  assign ir_mux  = ir_pin_select ? pin_sync_r[PIN_GENERAL_PIN_TWELVE]
                                 : pin_sync_r[PIN_IR_B];
  assign ir_edge = ir_mux ^ ir_level_r;

  // Tracking the pin through reset avoids a false edge afterwards.
  always_ff @(posedge sys_clk) begin
    ir_level_r <= ir_mux;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || pin_sync_r[PIN_SB_POR]) begin
      ir_flag_r <= 1'b0; // RL13
    end else if (ir_edge) begin
      ir_flag_r <= 1'b1; // RL10
    end else if (wr_msc && reg_req.addr == OFS_STS_B &&
                 reg_req.wdata[STS_B_IR_BIT]) begin
      ir_flag_r <= 1'b0; // RL12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || pin_sync_r[PIN_SB_POR]) begin
      btn_flag_r <= 1'b0; // RL13
    end else if (button_delay_start) begin
      btn_flag_r <= 1'b1; // RL11
    end else if (wr_msc && reg_req.addr == OFS_STS_B &&
                 reg_req.wdata[STS_B_BTN_BIT]) begin
      btn_flag_r <= 1'b0; // RL12
    end
  end

  // Status bits cleared at source are shown live from their sources.
  assign sts_a = src_a_in; // RL8
  assign sts_b = {2'b00,                       // RL9
                  src_b_in.mgmt_bus_irq_status,
                  src_b_in.kbc_port_pin_status,
                  btn_flag_r,
                  ir_flag_r,
                  src_b_in.keyboard_irq_status,
                  src_b_in.mouse_irq_status};

  always_comb begin
    rdata_nxt = RDATA_RST;
    if (rd_pm) begin
      case (reg_req.addr)
        OFS_CNT_LOW:   rdata_nxt = pm_count_value_r[7:0];
        OFS_CNT_MID:   rdata_nxt = count_snap_r[7:0]; // RL6
        OFS_CNT_HIGH:  rdata_nxt = count_snap_r[15:8]; // RL6
        OFS_CNT_SPARE: rdata_nxt = CNT_SPARE_VAL; // RL7
        default:       rdata_nxt = RDATA_RST;
      endcase
    end else if (rd_msc) begin
      case (reg_req.addr)
        OFS_STS_A: rdata_nxt = sts_a; // RL8
        OFS_STS_B: rdata_nxt = sts_b; // RL9
        OFS_EN_A:  rdata_nxt = sci_source_enable_a_r; // RL14
        default:   rdata_nxt = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_r <= RDATA_RST;
    end else begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  assign group_nxt = (|(sts_a & sci_source_enable_a_r)) |          // RL16
                     (|(sts_b[EN_B_W-1:0] & sci_enable_b)) |       // RL15
                     (count_msb_toggle_flag_r & count_event_enable); // RL5

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      group_sci_r <= 1'b0;
      sci_irq_r   <= 1'b0;
    end else begin
      group_sci_r <= group_nxt; // RL16
      sci_irq_r   <= group_nxt & sci_master_enable; // RL15 RL18
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_COUNT_INC: assert property ( // RL1
    count_inc && !count_clr |=>
      pm_count_value_r == $past(pm_count_value_r) + 24'h000001)
    else $error("Count did not advance on an enabled tick.");

  AST_COUNT_CLR: assert property ( // RL2
    count_clr |=> pm_count_value_r == COUNT_RST)
    else $error("Count not cleared by a reset input.");

  AST_COUNT_HOLD: assert property ( // RL3
    !count_tick && !count_clr |=> $stable(pm_count_value_r))
    else $error("Count moved without a reference tick.");

  AST_RUN_OFF: assert property ( // RL19
    !count_run_control && !count_clr |=> $stable(pm_count_value_r))
    else $error("Count moved while run control is off.");

  AST_MSB_FLAG: assert property ( // RL4
    $changed(pm_count_value_r[COUNT_MSB]) && !$past(count_clr) &&
      !$past(pin_sync_r[PIN_SB_POR]) && !$past(rst) |->
      count_msb_toggle_flag_r)
    else $error("Bit 23 change did not set the flag.");

  AST_EVENT_IRQ: assert property ( // RL5
    count_msb_toggle_flag_r && count_event_enable && sci_master_enable
      |=> sci_irq_r)
    else $error("Timer event did not raise the interrupt.");

  AST_SPARE_ZERO: assert property ( // RL7
    rd_pm && reg_req.addr == OFS_CNT_SPARE |=> reg_rdata_r == 8'h00)
    else $error("Spare count byte did not read zero.");

  AST_SNAPSHOT: assert property ( // RL17
    rd_pm && reg_req.addr == OFS_CNT_LOW && !count_clr |=>
      count_snap_r == $past(pm_count_value_r[23:8]))
    else $error("Low byte read did not latch upper bytes.");

  AST_STS_B_TOP: assert property ( // RL9
    rd_msc && reg_req.addr == OFS_STS_B |=> reg_rdata_r[7:6] == 2'b00)
    else $error("Second status bits 7:6 not zero.");

  AST_BTN_SET: assert property ( // RL11
    button_delay_start && !pin_sync_r[PIN_SB_POR] |=> btn_flag_r)
    else $error("Button start did not set its status bit.");

  AST_IR_SET: assert property ( // RL10
    ir_edge && !pin_sync_r[PIN_SB_POR] |=> ir_flag_r)
    else $error("Infrared edge did not set its status bit.");

  AST_ZERO_WRITE: assert property ( // RL12
    wr_msc && reg_req.addr == OFS_STS_B && !reg_req.wdata[STS_B_IR_BIT] &&
      ir_flag_r && !pin_sync_r[PIN_SB_POR] |=> ir_flag_r)
    else $error("Writing zero cleared the infrared bit.");

  AST_POR_CLEAR: assert property ( // RL13
    pin_sync_r[PIN_SB_POR] |=> !ir_flag_r && !btn_flag_r &&
      sci_source_enable_a_r == EN_A_RST)
    else $error("Standby reset left flags or enables set.");

  AST_EN_READ: assert property ( // RL14
    rd_msc && reg_req.addr == OFS_EN_A |=>
      reg_rdata_r == $past(sci_source_enable_a_r))
    else $error("Enable register read mismatch.");

  AST_GROUP: assert property ( // RL16
    (|(sts_a & sci_source_enable_a_r)) |=> group_sci_r)
    else $error("Enabled source did not reach the group output.");

  AST_MASTER_OFF: assert property ( // RL18
    !sci_master_enable |=> !sci_irq_r)
    else $error("Interrupt raised with master enable off.");

  // Nothing enabled and pending must leave the group output low.
  AST_GROUP_QUIET: assert property ( // RL16
    !(|(sts_a & sci_source_enable_a_r)) &&
      !(|(sts_b[EN_B_W-1:0] & sci_enable_b)) &&
      !(count_msb_toggle_flag_r && count_event_enable) |=> !group_sci_r)
    else $error("Group output high with nothing enabled pending.");

  AST_IRQ_GATE: assert property ( // RL15
    (|(sts_b[EN_B_W-1:0] & sci_enable_b)) && sci_master_enable |=>
      sci_irq_r)
    else $error("Group request did not reach the interrupt pin.");

  AST_STS_A_READ: assert property ( // RL8
    rd_msc && reg_req.addr == OFS_STS_A |=>
      reg_rdata_r == $past(src_a_in))
    else $error("First status read does not match the sources.");

  AST_STS_B_READ: assert property ( // RL9
    rd_msc && reg_req.addr == OFS_STS_B |=>
      {reg_rdata_r[5:4], reg_rdata_r[1:0]} == $past(src_b_in))
    else $error("Second status read does not match the sources.");

  AST_BTN_CLEAR: assert property ( // RL12
    wr_msc && reg_req.addr == OFS_STS_B && reg_req.wdata[STS_B_BTN_BIT] &&
      !button_delay_start |=> !btn_flag_r)
    else $error("Writing one did not clear the button bit.");

  AST_IR_CLEAR: assert property ( // RL12
    wr_msc && reg_req.addr == OFS_STS_B && reg_req.wdata[STS_B_IR_BIT] &&
      !ir_edge |=> !ir_flag_r)
    else $error("Writing one did not clear the infrared bit.");

  // A snapshot changes only on a low byte read or a count clear.
  AST_SNAP_HOLD: assert property ( // RL17
    !(rd_pm && reg_req.addr == OFS_CNT_LOW) && !count_clr |=>
      $stable(count_snap_r))
    else $error("Upper count bytes changed without a low byte read.");

  AST_COUNT_RO: assert property ( // RL6
    reg_req.wr && !count_inc && !count_clr |=> $stable(pm_count_value_r))
    else $error("A register write moved the count.");

  AST_FLAG_CLEAR: assert property ( // RL4
    count_flag_clear && !(count_inc && msb_flip) |=>
      !count_msb_toggle_flag_r)
    else $error("Flag clear did not take effect.");

  COV_TICK: cover property (count_inc ##[1:40] count_inc);
  COV_MSB: cover property (count_inc && msb_flip);
  COV_IRQ: cover property (!sci_irq_r ##1 sci_irq_r);
  COV_IR_CLR: cover property (ir_flag_r ##1 !ir_flag_r);
  COV_SNAP: cover property (rd_pm && reg_req.addr == OFS_CNT_LOW &&
    pm_count_value_r[8]);

endmodule

// >>> testbench/pm_timer_sci_status_tb_top.sv
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module pm_timer_sci_status_tb_top
  import pm_sci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          sys_clk, rst, ref_clk_pin, bus_reset_input;
  logic          standby_power_on_reset, working_state, count_run_control;
  logic          count_event_enable, sci_master_enable, count_flag_clear;
  logic          infrared_rx_pin_b, general_pin_twelve, ir_pin_select;
  logic          button_delay_start;
  logic [5:0]    sci_enable_b;
  reg_req_t      reg_req;
  src_status_a_t src_a_in;
  src_status_b_t src_b_in;
  logic [7:0]    reg_rdata_r, d;
  logic [23:0]   cnt;
  logic          flag, group_sci_r, sci_irq_r;
  int            n_errors, compares;

  pm_timer_sci_status dut (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata_r(reg_rdata_r), .ref_clk_pin(ref_clk_pin),
    .bus_reset_input(bus_reset_input),
    .standby_power_on_reset(standby_power_on_reset),
    .working_state(working_state), .count_run_control(count_run_control),
    .count_event_enable(count_event_enable),
    .sci_master_enable(sci_master_enable),
    .count_flag_clear(count_flag_clear), .src_a_in(src_a_in),
    .src_b_in(src_b_in), .infrared_rx_pin_b(infrared_rx_pin_b),
    .general_pin_twelve(general_pin_twelve), .ir_pin_select(ir_pin_select),
    .button_delay_start(button_delay_start), .sci_enable_b(sci_enable_b),
    .count_msb_toggle_flag_r(flag), .group_sci_r(group_sci_r),
    .sci_irq_r(sci_irq_r));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input blk_sel_t b, input logic [3:0] a,
                    output logic [7:0] q);
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, blk: b, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 q = reg_rdata_r;
  endtask

  task automatic wr(input blk_sel_t b, input logic [3:0] a,
                    input logic [7:0] v);
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, blk: b, addr: a, wdata: v};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask

  // The low byte is read first so that the upper bytes come from one snapshot.
  task automatic rd_count(output logic [23:0] c);
    rd(BLK_PM, OFS_CNT_LOW, c[7:0]);
    rd(BLK_PM, OFS_CNT_MID, c[15:8]);
    rd(BLK_PM, OFS_CNT_HIGH, c[23:16]);
  endtask

  // Each reference period spans six system cycles.
  task automatic ref_edges(input int n);
    repeat (n) begin
      @(posedge sys_clk) ref_clk_pin <= 1'b1;
      cyc(2);
      @(posedge sys_clk) ref_clk_pin <= 1'b0;
      cyc(2);
    end
  endtask

  task automatic pin_reset(input logic sb);
    @(posedge sys_clk);
    if (sb) standby_power_on_reset <= 1'b1;
    else bus_reset_input <= 1'b1;
    cyc(4);
    @(posedge sys_clk);
    standby_power_on_reset <= 1'b0;
    bus_reset_input <= 1'b0;
    cyc(6);
  endtask

  task automatic t_regs();
    @(posedge sys_clk);
    src_a_in <= 8'ha5;
    src_b_in <= 4'hf;
    rd(BLK_MSC, OFS_STS_A, d); `CHK(d, 8'ha5)
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h33)
    rd(BLK_MSC, OFS_EN_A, d); `CHK(d, EN_A_RST)
    wr(BLK_MSC, OFS_EN_A, 8'h5a);
    rd(BLK_MSC, OFS_EN_A, d); `CHK(d, 8'h5a)
    wr(BLK_MSC, OFS_STS_A, 8'hff);
    rd(BLK_MSC, OFS_STS_A, d); `CHK(d, 8'ha5)
    rd(BLK_PM, OFS_CNT_SPARE, d); `CHK(d, 8'h00)
    wr(BLK_PM, OFS_CNT_HIGH, 8'hff);
    rd(BLK_PM, OFS_CNT_HIGH, d); `CHK(d, 8'h00)
    rd(BLK_MSC, 4'h5, d); `CHK(d, 8'h00)
    @(posedge sys_clk);
    src_a_in <= 8'h00;
    src_b_in <= 4'h0;
    $display("test regs done");
  endtask

  task automatic t_group();
    wr(BLK_MSC, OFS_EN_A, 8'h80);
    @(posedge sys_clk);
    src_a_in <= 8'h7f;
    sci_master_enable <= 1'b1;
    cyc(3); `CHK(group_sci_r, 1'b0)
    @(posedge sys_clk) src_a_in <= 8'h80;
    cyc(3); `CHK(group_sci_r, 1'b1)
    `CHK(sci_irq_r, 1'b1)
    @(posedge sys_clk) sci_master_enable <= 1'b0;
    cyc(3); `CHK(sci_irq_r, 1'b0)
    `CHK(group_sci_r, 1'b1)
    @(posedge sys_clk) src_a_in <= 8'h00;
    $display("test group done");
  endtask

  task automatic t_count();
    @(posedge sys_clk) working_state <= 1'b1;
    ref_edges(8);
    rd_count(cnt); `CHK(cnt, 24'h000000)
    @(posedge sys_clk) count_run_control <= 1'b1;
    ref_edges(40);
    cyc(8);
    rd_count(cnt); `CHK(cnt, 24'h00000a)
    cyc(40);
    rd_count(cnt); `CHK(cnt, 24'h00000a)
    @(posedge sys_clk) working_state <= 1'b0;
    ref_edges(8);
    rd_count(cnt); `CHK(cnt, 24'h00000a)
    @(posedge sys_clk) working_state <= 1'b1;
    ref_edges(8);
    cyc(8);
    rd_count(cnt); `CHK(cnt, 24'h00000c)
    ref_edges(1024);
    cyc(8);
    rd_count(cnt); `CHK(cnt, 24'h00010c)
    ref_edges(1024);
    cyc(8);
    rd(BLK_PM, OFS_CNT_MID, d); `CHK(d, 8'h01)
    rd(BLK_PM, OFS_CNT_LOW, d); `CHK(d, 8'h0c)
    rd(BLK_PM, OFS_CNT_MID, d); `CHK(d, 8'h02)
    @(posedge sys_clk) count_event_enable <= 1'b1;
    cyc(2);
    `CHK(flag, 1'b0)
    `CHK(group_sci_r, 1'b0)
    pin_reset(1'b0);
    rd_count(cnt); `CHK(cnt, COUNT_RST)
    $display("test count done");
  endtask

  task automatic t_ir();
    @(posedge sys_clk);
    sci_enable_b <= 6'h04;
    sci_master_enable <= 1'b1;
    general_pin_twelve <= ~general_pin_twelve;
    cyc(8);
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h00)
    @(posedge sys_clk) infrared_rx_pin_b <= ~infrared_rx_pin_b;
    cyc(8);
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h04)
    `CHK(sci_irq_r, 1'b1)
    wr(BLK_MSC, OFS_STS_B, 8'hfb);
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h04)
    wr(BLK_MSC, OFS_STS_B, 8'h04);
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h00)
    @(posedge sys_clk) ir_pin_select <= 1'b1;
    cyc(8);
    @(posedge sys_clk) general_pin_twelve <= ~general_pin_twelve;
    cyc(8);
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h04)
    $display("test ir done");
  endtask

  task automatic t_button();
    @(posedge sys_clk) button_delay_start <= 1'b1;
    @(posedge sys_clk) button_delay_start <= 1'b0;
    cyc(2);
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h0c)
    wr(BLK_MSC, OFS_EN_A, 8'hff);
    pin_reset(1'b1);
    rd(BLK_MSC, OFS_STS_B, d); `CHK(d, 8'h00)
    rd(BLK_MSC, OFS_EN_A, d); `CHK(d, EN_A_RST)
    $display("test button done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    standby_power_on_reset = 1'b1;
    {ref_clk_pin, bus_reset_input, working_state} = 3'h0;
    {count_run_control, count_event_enable, sci_master_enable} = 3'h0;
    {count_flag_clear, infrared_rx_pin_b, general_pin_twelve} = 3'h0;
    {ir_pin_select, button_delay_start} = 2'h0;
    sci_enable_b = 6'h00;
    reg_req = '0;
    src_a_in = '0;
    src_b_in = '0;
    n_errors = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    standby_power_on_reset <= 1'b0;
    cyc(6);
    t_regs();
    t_group();
    t_count();
    t_ir();
    t_button();
    wrap_up();
  end
endmodule
